// >>> src/csf_status_flags.sv
// CPU status flag register with APB access and event interrupt
// What this block does
// - A subtract-without-borrow loads the compound-zero flag with the new zero flag.
// - A subtract-with-borrow sets compound-zero to its old value ANDed with the new zero.
// - Every other instruction leaves the compound-zero flag unchanged.
// - Watchdog time-out flag (bit 5) clears at power-up, watchdog clear or halt; sets on time-out.
// - The power-down flag (bit 4) sets when halt executes.
// - Overflow (bit 3) is carry into the MSB XOR carry out of it.
// - Zero (bit 2) is set when the result is zero and cleared otherwise.
// - Carry (bit 0) is the adder carry out, meaning no borrow for subtraction.
// - The power-down flag clears at power-up and on watchdog clear.
// - Auxiliary carry is the low nibble carry, meaning no nibble borrow for subtraction.
// - Software writes never change the time-out and power-down bits.
// - Sign-XOR flag is the new overflow XOR the result MSB.
`timescale 1ns/1ps
`include "csf_consts.svh"
module csf_status_flags (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire csf_pkg::csf_alu_t aluIn, // ALU result and class
    input wire csf_pkg::csf_sys_t sysIn, // System events
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic [7:0] cpuFlags, // Current flag byte
    output logic irq // Level interrupt
);
    logic [7:0] flags_r;
    logic [`CSF_IRQ_W-1:0] irqStat_r;
    logic [`CSF_IRQ_W-1:0] irqMask_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic apbWr;
    logic apbRd;
    logic zeroNew;
    logic ovNew;
    logic [7:0] flags_nxt;

    function automatic logic isMapped(input logic [11:0] a);
        return a == `CSF_OFF_FLAGS || a == `CSF_OFF_IRQ_STAT || a == `CSF_OFF_IRQ_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    assign apbWr = psel && penable && pwrite && pstrb[0];
    assign apbRd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign cpuFlags = flags_r;

    ////////////////////////////////////////////////////////////////////////////////
    assign zeroNew = aluIn.result == 8'h00;
    assign ovNew = aluIn.carryIntoMsb ^ aluIn.carryOut;

    always_comb
    begin
        flags_nxt = flags_r;
        // Software write first, so a same-cycle ALU update overrides it
        if (apbWr && paddr == `CSF_OFF_FLAGS)
            flags_nxt = (pwdata[7:0] & ~`CSF_SYS_MASK) | (flags_r & `CSF_SYS_MASK);
        if (aluIn.valid && aluIn.op != csf_pkg::CSF_OP_NONE)
        begin
            flags_nxt[`CSF_BIT_Z] = zeroNew;
            flags_nxt[`CSF_BIT_SC] = ovNew ^ aluIn.result[7];
            if (aluIn.op != csf_pkg::CSF_OP_LOGIC)
            begin
                flags_nxt[`CSF_BIT_C] = aluIn.carryOut;
                flags_nxt[`CSF_BIT_AC] = aluIn.nibbleCarry;
                flags_nxt[`CSF_BIT_OV] = ovNew;
            end
            unique case (aluIn.op)
                csf_pkg::CSF_OP_SUB: flags_nxt[`CSF_BIT_CZ] = zeroNew;
                csf_pkg::CSF_OP_SBC: flags_nxt[`CSF_BIT_CZ] = flags_r[`CSF_BIT_CZ] & zeroNew;
                default: flags_nxt[`CSF_BIT_CZ] = flags_r[`CSF_BIT_CZ];
            endcase
        end
        // Time-out has priority over a same-cycle clear so the event is not lost
        if (sysIn.watchdogClear || sysIn.halt)
            flags_nxt[`CSF_BIT_TO] = 1'b0;
        if (sysIn.watchdogTimeout)
            flags_nxt[`CSF_BIT_TO] = 1'b1;
        if (sysIn.watchdogClear)
            flags_nxt[`CSF_BIT_PD] = 1'b0;
        if (sysIn.halt)
            flags_nxt[`CSF_BIT_PD] = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            flags_r <= `CSF_FLAGS_RST;
        else
            flags_r <= flags_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over write-one-to-clear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            irqStat_r <= '0;
        else
        begin
            logic [`CSF_IRQ_W-1:0] clr;
            logic [`CSF_IRQ_W-1:0] set;
            clr = '0;
            set = '0;
            if (apbWr && paddr == `CSF_OFF_IRQ_STAT)
                clr = pwdata[`CSF_IRQ_W-1:0];
            set[`CSF_IRQ_WD] = sysIn.watchdogTimeout;
            set[`CSF_IRQ_HALT] = sysIn.halt;
            irqStat_r <= (irqStat_r & ~clr) | set;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            irqMask_r <= '0;
        else if (apbWr && paddr == `CSF_OFF_IRQ_MASK)
            irqMask_r <= pwdata[`CSF_IRQ_W-1:0];
    end

    assign irq = |(irqStat_r & irqMask_r);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pslverr_r <= psel && !penable && !isMapped(paddr);
            prdata_r <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    `CSF_OFF_FLAGS: prdata_r <= {24'h000000, flags_r};
                    `CSF_OFF_IRQ_STAT: prdata_r <= {30'h0, irqStat_r};
                    `CSF_OFF_IRQ_MASK: prdata_r <= {30'h0, irqMask_r};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_cz_sub_copy: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SUB && !sysIn.halt
        |=> flags_r[`CSF_BIT_CZ] == $past(zeroNew))
        else $error("compound zero not equal to zero after subtract");
    a_cz_sbc_and: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SBC
        |=> flags_r[`CSF_BIT_CZ] == ($past(flags_r[`CSF_BIT_CZ]) & $past(zeroNew)))
        else $error("compound zero not ANDed on subtract with borrow");
    a_cz_hold_other: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(aluIn.valid && (aluIn.op == csf_pkg::CSF_OP_SUB || aluIn.op == csf_pkg::CSF_OP_SBC))
        && !(apbWr && paddr == `CSF_OFF_FLAGS) |=> $stable(flags_r[`CSF_BIT_CZ]))
        else $error("compound zero changed by other instruction");
    a_to_events: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.watchdogTimeout |=> flags_r[`CSF_BIT_TO])
        else $error("time-out flag not set on time-out");
    a_to_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sysIn.watchdogClear || sysIn.halt) && !sysIn.watchdogTimeout |=> !flags_r[`CSF_BIT_TO])
        else $error("time-out flag not cleared");
    a_pd_halt: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.halt |=> flags_r[`CSF_BIT_PD])
        else $error("power-down flag not set on halt");
    a_pd_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.watchdogClear && !sysIn.halt |=> !flags_r[`CSF_BIT_PD])
        else $error("power-down flag not cleared");
    a_ov_zero_c: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_ADD |=> flags_r[`CSF_BIT_OV] == $past(ovNew)
        && flags_r[`CSF_BIT_Z] == $past(zeroNew) && flags_r[`CSF_BIT_C] == $past(aluIn.carryOut))
        else $error("arithmetic flags wrong after add");
    a_ac_sc_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SUB |=>
        flags_r[`CSF_BIT_AC] == $past(aluIn.nibbleCarry)
        && flags_r[`CSF_BIT_SC] == ($past(ovNew) ^ $past(aluIn.result[7])))
        else $error("aux carry or sign flag wrong");
    a_sys_wr_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
        apbWr && paddr == `CSF_OFF_FLAGS && !sysIn.halt && !sysIn.watchdogClear
        && !sysIn.watchdogTimeout |=> $stable(flags_r[5:4]))
        else $error("software changed system flags");
    c_sbc_chain: cover property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SUB ##1 aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SBC);
    c_halt: cover property (@(posedge clk_sys) disable iff (!resetn) sysIn.halt ##1 irq);
    c_timeout_clear: cover property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.watchdogTimeout ##[1:5] sysIn.watchdogClear);
    c_sw_write: cover property (@(posedge clk_sys) disable iff (!resetn)
        apbWr && paddr == `CSF_OFF_FLAGS);

    a_logic_z_sc: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_LOGIC |=> flags_r[`CSF_BIT_Z] == $past(zeroNew)
        && flags_r[`CSF_BIT_SC] == ($past(ovNew) ^ $past(aluIn.result[7])))
        else $error("zero or sign flag wrong after logic op");

    a_logic_keeps_c: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_LOGIC && !(apbWr && paddr == `CSF_OFF_FLAGS)
        |=> $stable(flags_r[1:0]) && $stable(flags_r[`CSF_BIT_OV]))
        else $error("logic op changed carry flags");

    a_sub_arith: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SUB |=> flags_r[`CSF_BIT_OV] == $past(ovNew)
        && flags_r[`CSF_BIT_Z] == $past(zeroNew) && flags_r[`CSF_BIT_C] == $past(aluIn.carryOut))
        else $error("arithmetic flags wrong after subtract");

    a_sbc_arith: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SBC |=> flags_r[`CSF_BIT_OV] == $past(ovNew)
        && flags_r[`CSF_BIT_C] == $past(aluIn.carryOut)
        && flags_r[`CSF_BIT_AC] == $past(aluIn.nibbleCarry))
        else $error("carry flags wrong after subtract with borrow");

    a_sbc_z_sc: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_SBC |=> flags_r[`CSF_BIT_Z] == $past(zeroNew)
        && flags_r[`CSF_BIT_SC] == ($past(ovNew) ^ $past(aluIn.result[7])))
        else $error("zero or sign flag wrong after subtract with borrow");

    a_add_ac_sc: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_ADD |=> flags_r[`CSF_BIT_AC] == $past(aluIn.nibbleCarry)
        && flags_r[`CSF_BIT_SC] == ($past(ovNew) ^ $past(aluIn.result[7])))
        else $error("aux carry or sign flag wrong after add");

    a_cz_add_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        aluIn.valid && aluIn.op == csf_pkg::CSF_OP_ADD && !(apbWr && paddr == `CSF_OFF_FLAGS)
        |=> $stable(flags_r[`CSF_BIT_CZ]))
        else $error("compound zero changed by add");

    a_sw_wr_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        apbWr && paddr == `CSF_OFF_FLAGS && !(aluIn.valid && aluIn.op != csf_pkg::CSF_OP_NONE)
        |=> flags_r[7:6] == $past(pwdata[7:6]) && flags_r[3:0] == $past(pwdata[3:0]))
        else $error("software write to flags not taken");

    a_to_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.watchdogTimeout && (sysIn.watchdogClear || sysIn.halt)
        |=> flags_r[`CSF_BIT_TO])
        else $error("time-out lost to same-cycle clear");

    a_pd_halt_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.halt && sysIn.watchdogClear
        |=> flags_r[`CSF_BIT_PD])
        else $error("power-down lost to same-cycle clear");

    a_sys_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !sysIn.watchdogTimeout && !sysIn.watchdogClear && !sysIn.halt
        |=> $stable(flags_r[5:4]))
        else $error("system flags changed without event");

    a_stat_wd_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.watchdogTimeout
        |=> irqStat_r[`CSF_IRQ_WD])
        else $error("time-out status bit not set");

    a_stat_halt_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        sysIn.halt
        |=> irqStat_r[`CSF_IRQ_HALT])
        else $error("halt status bit not set");

    a_stat_w1c: assert property (@(posedge clk_sys) disable iff (!resetn)
        apbWr && paddr == `CSF_OFF_IRQ_STAT && pwdata[`CSF_IRQ_WD] && !sysIn.watchdogTimeout
        |=> !irqStat_r[`CSF_IRQ_WD])
        else $error("status bit not cleared by writing one");

    a_stat_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !sysIn.watchdogTimeout && !sysIn.halt && !(apbWr && paddr == `CSF_OFF_IRQ_STAT)
        |=> $stable(irqStat_r))
        else $error("status changed without event or clear");

    a_mask_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        apbWr && paddr == `CSF_OFF_IRQ_MASK
        |=> irqMask_r == $past(pwdata[`CSF_IRQ_W-1:0]))
        else $error("mask write not taken");

    a_rd_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
        psel && !penable && !pwrite && paddr == `CSF_OFF_FLAGS
        |=> prdata == {24'h000000, $past(flags_r)})
        else $error("read data of flag register wrong");

    a_rd_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(psel && !penable && !pwrite)
        |=> prdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!resetn)
        psel && !penable && !isMapped(paddr)
        |=> pslverr)
        else $error("no error on unmapped address");

    a_err_mapped: assert property (@(posedge clk_sys) disable iff (!resetn)
        psel && !penable && isMapped(paddr)
        |=> !pslverr)
        else $error("error on mapped address");
endmodule

// >>> src/csf_consts.svh
// Offsets, field positions, reset values and counts of the CPU status flag block
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH
`define CSF_OFF_FLAGS 12'h000
`define CSF_OFF_IRQ_STAT 12'h004
`define CSF_OFF_IRQ_MASK 12'h008
`define CSF_BIT_C 0
`define CSF_BIT_AC 1
`define CSF_BIT_Z 2
`define CSF_BIT_OV 3
`define CSF_BIT_PD 4
`define CSF_BIT_TO 5
`define CSF_BIT_CZ 6
`define CSF_BIT_SC 7
`define CSF_FLAGS_RST 8'h00
`define CSF_SYS_MASK 8'h30
`define CSF_IRQ_WD 0
`define CSF_IRQ_HALT 1
`define CSF_IRQ_W 2
`endif

// >>> src/csf_pkg.sv
// Types of the CPU status flag block
package csf_pkg;
    typedef enum logic [2:0] {
        CSF_OP_NONE = 3'b000,
        CSF_OP_ADD = 3'b001,
        CSF_OP_SUB = 3'b010,
        CSF_OP_SBC = 3'b011,
        CSF_OP_LOGIC = 3'b100
    } csf_op_t;
    typedef struct packed {
        logic valid;
        csf_op_t op;
        logic [7:0] result;
        logic carryOut;
        logic carryIntoMsb;
        logic nibbleCarry;
    } csf_alu_t;
    typedef struct packed {
        logic watchdogTimeout;
        logic watchdogClear;
        logic halt;
    } csf_sys_t;
endpackage

// >>> tb/csf_alu_model.sv
// ALU and decoder model that feeds results and carries to the flag block
`timescale 1ns/1ps
module csf_alu_model (
    input wire logic valid, // Instruction issued this cycle
    input wire csf_pkg::csf_op_t op, // Instruction class
    input wire logic [7:0] opA, // First operand
    input wire logic [7:0] opB, // Second operand
    input wire logic carryIn, // Carry flag, used by borrow forms
    output csf_pkg::csf_alu_t aluOut // Result and carries
);
    logic [7:0] b;
    logic cin;
    logic [8:0] sum;
    logic [7:0] low7;
    logic [4:0] nib;
    always_comb
    begin
        // Subtraction is addition of the complement, so carry means no borrow
        b = (op == csf_pkg::CSF_OP_ADD) ? opB : ~opB;
        cin = (op == csf_pkg::CSF_OP_SUB) | ((op == csf_pkg::CSF_OP_SBC) & carryIn);
        sum = {1'b0, opA} + {1'b0, b} + {8'h00, cin};
        low7 = {1'b0, opA[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        nib = {1'b0, opA[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        aluOut.valid = valid;
        aluOut.op = op;
        // Logic ops report no carries so the flag block sees a clean overflow
        aluOut.result = (op == csf_pkg::CSF_OP_LOGIC) ? (opA & opB) : sum[7:0];
        aluOut.carryOut = (op != csf_pkg::CSF_OP_LOGIC) & sum[8];
        aluOut.carryIntoMsb = (op != csf_pkg::CSF_OP_LOGIC) & low7[7];
        aluOut.nibbleCarry = (op != csf_pkg::CSF_OP_LOGIC) & nib[4];
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the CPU status flag block
`timescale 1ns/1ps
module tb;
    logic clk_sys = 0;
    logic resetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, aluValid = 0, carryIn = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] cpuFlags, opA = 8'h00, opB = 8'h00;
    csf_pkg::csf_op_t aluOp = csf_pkg::CSF_OP_NONE;
    csf_pkg::csf_alu_t aluIn;
    csf_pkg::csf_sys_t sysIn = '0;
    int errCount = 0, checkCount = 0, cycles = 0;
    logic err;
    always #5 clk_sys = ~clk_sys;
    csf_alu_model i_alu (.valid(aluValid), .op(aluOp), .opA(opA), .opB(opB),
        .carryIn(carryIn), .aluOut(aluIn));
    csf_status_flags i_dut (.clk_sys(clk_sys), .resetn(resetn), .aluIn(aluIn), .sysIn(sysIn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpuFlags(cpuFlags), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (errCount == 0 && checkCount > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Answer is taken at the edge that samples pready high, before that edge's updates land
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do
        begin
            @(posedge clk_sys);
            rd = prdata;
            err = pslverr;
            rdy = pready;
        end
        while (rdy !== 1'b1);
        psel <= 0;
        penable <= 0;
        // Let the registers written at that edge settle before callers compare outputs
        #1;
    endtask
    task automatic alu(input csf_pkg::csf_op_t o, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] e);
        @(posedge clk_sys);
        aluValid <= 1;
        aluOp <= o;
        opA <= a;
        opB <= b;
        carryIn <= cpuFlags[0];
        @(posedge clk_sys);
        aluValid <= 0;
        #1 chk({24'h0, cpuFlags}, {24'h0, e});
    endtask
    task automatic sys(input csf_pkg::csf_sys_t s, input logic [7:0] e);
        @(posedge clk_sys);
        sysIn <= s;
        @(posedge clk_sys);
        sysIn <= '0;
        #1 chk({24'h0, cpuFlags}, {24'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard, well above the fewer than 60 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errCount++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1;
        apb(0, 12'h000, 0);
        chk(rd, 32'h0);
        alu(csf_pkg::CSF_OP_ADD, 8'h0f, 8'h01, 8'h02);
        alu(csf_pkg::CSF_OP_ADD, 8'h7f, 8'h01, 8'h0a);
        alu(csf_pkg::CSF_OP_ADD, 8'h80, 8'h80, 8'h8d);
        alu(csf_pkg::CSF_OP_SUB, 8'h05, 8'h05, 8'h47);
        alu(csf_pkg::CSF_OP_LOGIC, 8'hff, 8'h80, 8'hc3);
        alu(csf_pkg::CSF_OP_SBC, 8'h03, 8'h03, 8'h47);
        alu(csf_pkg::CSF_OP_SBC, 8'h03, 8'h01, 8'h03);
        alu(csf_pkg::CSF_OP_SUB, 8'h00, 8'h01, 8'h80);
        apb(1, 12'h000, 32'hff);
        apb(0, 12'h000, 0);
        chk(rd, 32'hcf);
        sys(3'b100, 8'hef);
        sys(3'b001, 8'hdf);
        sys(3'b100, 8'hff);
        apb(1, 12'h000, 32'h00);
        chk({24'h0, cpuFlags}, 32'h30);
        sys(3'b010, 8'h00);
        apb(0, 12'h004, 0);
        chk({rd[31:0]}, 32'h3);
        chk({31'h0, irq}, 32'h0);
        apb(1, 12'h008, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1, 12'h004, 32'h1);
        apb(0, 12'h004, 0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        apb(0, 12'h00c, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        report_and_stop();
    end
endmodule
